//--- obs_chk.sv
`timescale 1ns/100ps
module obs_chk
   import obs_pkg::*;
(
   // Clock, reset and register side
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [11:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_hit,
   // Flash side and core outputs
   input wire logic stop_recovery_control_bit0,
   input wire logic mass_erase_done,
   input wire logic acc_req,
   input wire logic acc_from_in_circuit,
   input wire logic acc_opt_byte,
   input wire logic wide_stack_select,
   input wire logic clock_nodivide_select,
   input wire logic crystal_half_en,
   input wire logic [4:0] sp_width,
   input wire logic acc_grant,
   input wire logic option_load_busy
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   logic wr_hit;
   assign wr_hit = reg_wr && reg_addr == OBS_SHADOW_ADDR && !option_load_busy;
   a_hit_decode: assert property (reg_hit == (reg_addr == OBS_SHADOW_ADDR && (reg_wr || reg_rd)))
      else $error("hit decode");
   a_wr_fields: assert property (wr_hit |=> {wide_stack_select, clock_nodivide_select} == $past(reg_wdata[3:2]))
      else $error("write fields");
   a_rd_lag: assert property (wr_hit |-> ##2 reg_rdata[3:2] == $past(reg_wdata[3:2], 2))
      else $error("read back");
   a_lock_ro: assert property (wr_hit && !mass_erase_done |-> ##2 $stable(reg_rdata[1:0]))
      else $error("lock written");
   a_rsvd_zero: assert property (reg_rdata[7:4] == 4'h0)
      else $error("reserved bits");
   a_sp_width: assert property (sp_width == (wide_stack_select ? 5'd8 : 5'd16))
      else $error("stack width");
   a_clk_half: assert property (crystal_half_en == (clock_nodivide_select && !stop_recovery_control_bit0))
      else $error("clock halving");
   a_opt_in_circuit: assert property (acc_req && acc_opt_byte && !acc_from_in_circuit |-> !acc_grant)
      else $error("option byte access");
   a_erase_open: assert property (mass_erase_done |-> ##2 reg_rdata[1:0] == 2'h3)
      else $error("erase unlock");
endmodule : obs_chk
bind obs_shadow obs_chk i_obs_chk (.clk_sys, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
   .reg_rdata, .reg_hit, .stop_recovery_control_bit0, .mass_erase_done, .acc_req,
   .acc_from_in_circuit, .acc_opt_byte, .wide_stack_select, .clock_nodivide_select,
   .crystal_half_en, .sp_width, .acc_grant, .option_load_busy);

//--- obs_flash_side.sv
`timescale 1ns/100ps
module obs_flash_side
   import obs_pkg::*;
(
   // Control
   input wire logic clk_sys,
   input wire logic go,
   // Request {req, icp, main, upper, read, option}
   output logic [5:0] acc = 6'h0,
   output logic [7:0] page = 8'h0
);
   int seed = 32'h0363;
   logic [7:0] r;
   always @(posedge clk_sys) begin
      r = 8'($random(seed));
      // Option byte lives on page 3 only
      acc <= #1 go ? {r[5:1], r[0] & ~r[3] & r[6]} : 6'h0;
      page <= #1 r[6] ? OBS_INFO_PAGE_OPT : 8'h01;
   end
endmodule : obs_flash_side

//--- obs_lock_flops.sv
`timescale 1ns/100ps
module obs_lock_flops
   import obs_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Load and mass erase events
   input wire logic load_en,
   input wire logic [1:0] stored_locks,
   input wire logic mass_erase_done,
   // Sampled lock outputs
   output logic lower_half_lock,
   output logic main_array_lock
);
   // Closed until the load, open after a mass erase
   localparam logic [1:0] LOCKS_CLOSED = 2'b00;
   localparam logic [1:0] LOCKS_OPEN = 2'b11;
   logic [1:0] lock_r;
   logic [1:0] lock_nxt;

   always_comb begin
      lock_nxt = lock_r;
      if (load_en) begin
         lock_nxt = stored_locks;
      end
      if (mass_erase_done) begin
         lock_nxt = LOCKS_OPEN;
      end
   end

   // Reset leaves the locks closed until loaded, the safe side
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         lock_r <= LOCKS_CLOSED;
      end else begin
         lock_r <= lock_nxt;
      end
   end

   assign lower_half_lock = lock_r[1];
   assign main_array_lock = lock_r[0];
endmodule : obs_lock_flops

//--- obs_pkg.sv
package obs_pkg;
   // Register file location of the shadow byte
   localparam logic [11:0] OBS_SHADOW_ADDR = 12'hd0f;
   // Field positions
   localparam int OBS_BIT_MAIN_LOCK = 0;
   localparam int OBS_BIT_LOWER_LOCK = 1;
   localparam int OBS_BIT_NODIV = 2;
   localparam int OBS_BIT_WIDE_STACK = 3;
   // CPU writable field mask (bits 3 and 2)
   localparam logic [7:0] OBS_CPU_WR_MASK = 8'h0c;
   // Reserved upper nibble as the programmer must store it
   localparam logic [3:0] OBS_RSVD_STORED = 4'hf;
   // Preset of the no-divide bit at the start of reset
   localparam logic OBS_NODIV_PRESET = 1'b1;
   // Stack pointer widths
   localparam int OBS_SP_NARROW = 8;
   localparam int OBS_SP_WIDE = 16;
   // Information page holding the option bytes
   localparam logic [7:0] OBS_INFO_PAGE_OPT = 8'h03;
   // Option load sequencer states
   typedef enum logic [1:0] {
      OBS_ST_RESET = 2'b00,
      OBS_ST_LOAD = 2'b01,
      OBS_ST_RUN = 2'b10
   } obs_state_e;
endpackage : obs_pkg

//--- obs_shadow.sv
`timescale 1ns/100ps
// Behaviour
// - stack select one gives 8-bit pointer
// - stack select zero gives 16-bit pointer
// - no-divide one halves crystal clock while stop_recovery_control_bit0 is zero
// - no-divide zero passes crystal clock
// - lower lock zero blocks lower half
// - main lock zero blocks whole array
// - mass erase sets shadow locks only
// - erased shadow grants full access
// - full access needs both locks one
// - shadow at D0F, bits 1:0 read-only
// - reserved bits read zero, writes ignored
// - power-on samples stored lock bits
// - software cannot overwrite lock flops
// - byte programmed only through in-circuit port
module obs_shadow
   import obs_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Reset logic option load
   input wire logic option_load,
   input wire logic [7:0] option_byte_one,
   // Register file access
   input wire logic [11:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_hit,
   // Clock mode inputs
   input wire logic stop_recovery_control_bit0,
   // Flash access request from a programming interface
   input wire logic mass_erase_done,
   input wire logic acc_req,
   input wire logic acc_from_in_circuit,
   input wire logic acc_main,
   input wire logic acc_upper_half,
   input wire logic acc_is_read,
   input wire logic [7:0] acc_info_page,
   input wire logic acc_opt_byte,
   // Outputs to core
   output logic wide_stack_select,
   output logic clock_nodivide_select,
   output logic crystal_half_en,
   output logic [4:0] sp_width,
   output logic acc_grant,
   output logic option_load_busy
);
   obs_state_e state_r;
   obs_state_e state_nxt;
   logic stack_r;
   logic stack_nxt;
   logic nodiv_r;
   logic nodiv_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic lower_lock;
   logic main_lock;
   logic load_en;
   logic cpu_wr;
   logic shadow_sel;
   logic run_state;

   // Values the shadow fields take while reset is held
   localparam logic OBS_STACK_RESET = 1'b0;
   localparam logic [7:0] OBS_RDATA_RESET = 8'h00;

   // Register file decode, shared by the hit flag and the write strobe
   function automatic logic shadow_addr_match(input logic [11:0] addr);
      return addr == OBS_SHADOW_ADDR;
   endfunction : shadow_addr_match

   // Page 3 of the information area, outside the main array
   function automatic logic is_info_page3(input logic [7:0] page, input logic main);
      return (page == OBS_INFO_PAGE_OPT) && !main;
   endfunction : is_info_page3

   assign shadow_sel = shadow_addr_match(reg_addr);
   assign run_state = (state_r == OBS_ST_RUN);
   assign reg_hit = shadow_sel && (reg_wr || reg_rd);
   // Writes before the option load would be lost to the load, so refuse them
   assign cpu_wr = reg_wr && shadow_sel && run_state;
   assign load_en = (state_r == OBS_ST_LOAD);

   // Lock flops only see the load and the erase, never CPU writes
   // no CPU path
   obs_lock_flops u_locks (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .load_en(load_en),
      .stored_locks(option_byte_one[OBS_BIT_LOWER_LOCK:OBS_BIT_MAIN_LOCK]),
      .mass_erase_done(mass_erase_done),
      .lower_half_lock(lower_lock),
      .main_array_lock(main_lock)
   );

   // One load per reset, then the sequencer parks in run
   // A second option_load pulse is ignored until the next reset
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         OBS_ST_RESET: begin
            state_nxt = option_load ? OBS_ST_LOAD : OBS_ST_RESET;
         end
         OBS_ST_LOAD: begin
            state_nxt = OBS_ST_RUN;
         end
         OBS_ST_RUN: begin
            state_nxt = OBS_ST_RUN;
         end
         default: begin
            state_nxt = OBS_ST_RESET;
         end
      endcase
   end

   // Load takes priority over the CPU
   // The CPU may only touch the stack and clock bits
   always_comb begin
      stack_nxt = stack_r;
      nodiv_nxt = nodiv_r;
      if (load_en) begin
         stack_nxt = option_byte_one[OBS_BIT_WIDE_STACK];
         nodiv_nxt = option_byte_one[OBS_BIT_NODIV];
      end else if (cpu_wr) begin
         stack_nxt = reg_wdata[OBS_BIT_WIDE_STACK] & OBS_CPU_WR_MASK[OBS_BIT_WIDE_STACK];
         nodiv_nxt = reg_wdata[OBS_BIT_NODIV] & OBS_CPU_WR_MASK[OBS_BIT_NODIV];
      end
   end

   // Locks read back from the flops, never from a CPU copy
   // Registered so the read port meets timing at the cost of a cycle
   always_comb begin
      rdata_nxt = 8'h00;
      rdata_nxt[OBS_BIT_WIDE_STACK] = stack_r;
      rdata_nxt[OBS_BIT_NODIV] = nodiv_r;
      rdata_nxt[OBS_BIT_LOWER_LOCK] = lower_lock;
      rdata_nxt[OBS_BIT_MAIN_LOCK] = main_lock;
   end

   // Sequencer register
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_r <= OBS_ST_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Shadow field registers
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         stack_r <= OBS_STACK_RESET;
         nodiv_r <= OBS_NODIV_PRESET;
      end else begin
         stack_r <= stack_nxt;
         nodiv_r <= nodiv_nxt;
      end
   end

   // Read data register, one cycle behind the fields
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rdata_r <= OBS_RDATA_RESET;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;
   assign option_load_busy = !run_state;
   assign wide_stack_select = stack_r;
   assign clock_nodivide_select = nodiv_r;

   // Width handed to the stack logic as a bit count
   // narrow stack pointer
   assign sp_width = stack_r ? 5'(OBS_SP_NARROW) : 5'(OBS_SP_WIDE);

   // Only the enable is made here; the divider itself lives elsewhere
   // halve crystal clock
   assign crystal_half_en = nodiv_r && !stop_recovery_control_bit0;

   // Access decode is combinational so a request is answered in its own cycle
   // Page 3 reads stay open except option byte reads not from in-circuit; its writes and erases are guarded
   logic info3;
   logic blocked;
   always_comb begin
      info3 = is_info_page3(acc_info_page, acc_main);
      blocked = 1'b0;
      if (!main_lock && ((acc_main && acc_is_read) || !acc_is_read)) begin
         blocked = acc_main || info3;
      end
      if (!lower_lock) begin
         if (acc_main && !acc_upper_half) begin
            blocked = 1'b1;
         end
         if (info3 && !acc_is_read) begin
            blocked = 1'b1;
         end
      end
      if (acc_opt_byte && !acc_from_in_circuit) begin
         blocked = 1'b1;
      end
   end

   // Nothing is granted until the locks have been loaded
   // erased shadow opens access
   assign acc_grant = acc_req && !blocked && !option_load_busy;
endmodule : obs_shadow

//--- test_obs_shadow.sv
`timescale 1ns/100ps
module test_obs_shadow import obs_pkg::*; ;
   logic clk_sys = 0, rst_n = 0, opl = 0, wr = 0, rd = 0, srcb = 0, ers = 0, go = 0;
   logic [11:0] addr = 0;
   logic [7:0] ob = 0, wd = 0, rdata, page, m_rd, r;
   logic [5:0] acc;
   logic [4:0] spw;
   logic hit, stk, nd, half, gnt, busy, m_stk, m_nd, m_lo, m_ma;
   int seed = 32'h0363, n_fail = 0, compares = 0, ph = 0;
   always #2.5 clk_sys = ~clk_sys;
   obs_flash_side i_obs_flash_side (.clk_sys, .go, .acc, .page);
   obs_shadow i_obs_shadow (.clk_sys, .rst_n, .option_load(opl), .option_byte_one(ob),
      .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wd), .reg_rdata(rdata),
      .reg_hit(hit), .stop_recovery_control_bit0(srcb), .mass_erase_done(ers),
      .acc_req(acc[5]), .acc_from_in_circuit(acc[4]), .acc_main(acc[3]), .acc_upper_half(acc[2]),
      .acc_is_read(acc[1]), .acc_info_page(page), .acc_opt_byte(acc[0]),
      .wide_stack_select(stk), .clock_nodivide_select(nd), .crystal_half_en(half),
      .sp_width(spw), .acc_grant(gnt), .option_load_busy(busy));
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : check
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         {m_stk, m_nd, m_lo, m_ma} = {1'b0, OBS_NODIV_PRESET, 2'h0};
         m_rd = 8'h0;
         ph = 0;
      end else begin
         m_rd = {4'h0, m_stk, m_nd, m_lo, m_ma};
         if (ph == 2 && wr && addr == OBS_SHADOW_ADDR) {m_stk, m_nd} = wd[3:2];
         if (ph == 1) {m_stk, m_nd, m_lo, m_ma} = ob[3:0];
         if (ers) {m_lo, m_ma} = 2'h3;
         if (ph == 1) ph = 2;
         if (ph == 0 && opl) ph = 1;
      end
   end
   always @(negedge clk_sys) begin
      check("rdata", m_rd, rdata);
      check("nodiv", m_nd, nd);
      check("stack", m_stk, stk);
      check("sp", m_stk ? 8'd8 : 8'd16, spw);
      check("half", m_nd & !srcb, half);
      check("grant", acc[5] & !(acc[0] & !acc[4]) & !(acc[3] & !m_ma) & !(acc[3] & !acc[2] & !m_lo)
         & !(!acc[3] & page == 3 & !acc[1] & !(m_lo & m_ma)) & (ph == 2),
         gnt);
      check("busy", ph != 2, busy);
      check("hit", addr == OBS_SHADOW_ADDR && (wr | rd), hit);
   end
   initial begin
      // Each pass starts the stored locks at another combination
      for (int k = 0; k < 4; k++) begin
         rst_n = 0;
         repeat (3) @(posedge clk_sys);
         r = 8'($random(seed));
         #1 ob = {OBS_RSVD_STORED, r[7:6], 2'(k)};
         rst_n = 1;
         for (int n = 0; n < 60; n++) begin
            r = 8'($random(seed));
            addr = r[0] ? OBS_SHADOW_ADDR : 12'hd0e;
            {wr, rd, srcb} = r[3:1];
            wd = 8'($random(seed));
            ers = (n == 30 && k != 3);
            go = n > 3;
            opl = (n == 0);
            @(posedge clk_sys);
            #1;
         end
      end
      tally_and_finish;
   end
   task automatic tally_and_finish;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
endmodule : test_obs_shadow
